// ===== hw/sys_ctrl_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte addresses on the register port, one 32-bit word per register
// Notes:   included by the control block; the bench uses literal values
`ifndef SYS_CTRL_REGS_SVH
`define SYS_CTRL_REGS_SVH

// register byte offsets
`define OFS_BROWNOUT_CONTROL   9'h018
`define OFS_TEMP_SENSOR_CTRL   9'h01c
`define OFS_POWER_ON_RST_CTRL  9'h024
`define OFS_PORTA_FUNC_SELECT  9'h030
`define OFS_IRQ_STATUS         9'h040
`define OFS_IRQ_MASK           9'h044
`define OFS_PROTECTION_UNLOCK  9'h100

// brownout_control field positions
`define BIT_LVR_ON             7
`define BIT_UV_STATUS          6
`define BIT_UV_LOW_POWER       5
`define BIT_UV_EVENT_FLAG      4
`define BIT_UV_RESET_SELECT    3
`define BIT_UV_THRESH_HI       2
`define BIT_UV_THRESH_LO       1
`define BIT_UV_ENABLE          0

// flash user config word positions of the loaded defaults
`define CFG_BIT_UV_ENABLE      23
`define CFG_BIT_THRESH_HI      22
`define CFG_BIT_THRESH_LO      21
`define CFG_BIT_RESET_SELECT   20

// other field positions
`define BIT_THERMAL_EN         0
`define POS_SCHMITT_LO         16
`define POS_POR_CODE_HI        15

// interrupt status bit positions
`define IRQ_BIT_UV_CROSS       0
`define IRQ_BIT_LVR_READY      1
`define IRQ_BIT_PROT_VIOLATION 2
`define IRQ_W                  3

// reset values
`define RST_LVR_ON             1'b1
`define RST_UV_LOW_POWER       1'b0
`define RST_THERMAL_EN         1'b0
`define RST_POR_CODE           16'h0000
`define RST_PORTA_FUNC         32'h0000_0000
`define RST_IRQ_MASK           3'h0

// unlock sequence bytes and power-on-reset disable code
`define UNLOCK_BYTE0           8'h59
`define UNLOCK_BYTE1           8'h16
`define UNLOCK_BYTE2           8'h88
`define POR_DISABLE_CODE       16'h5aa5

// timing: settle time of the low-voltage reset output
`define CLK_PERIOD_NS          100
`define LVR_SETTLE_US          100
`define LVR_SETTLE_CYC         ((`LVR_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hw/sys_ctrl_pkg.sv
// Purpose: shared types of the system control block
// Assumes: constants live in sys_ctrl_regs.svh
// Notes:   nothing here is synthesised by itself
package sys_ctrl_pkg;

  // brownout control fields driven to the analog detector
  typedef struct packed {
    logic       lvr_on;     // low-voltage reset enable
    logic       low_power;  // detector low-power mode
    logic       rst_sel;    // 1 reset, 0 interrupt
    logic [1:0] threshold;  // 11 4.5V, 10 3.8V, 01 2.7V, 00 2.2V
    logic       enable;     // detector enable
  } uv_ctrl_type;

  // alternate-function settings that steer the port A multiplexer
  typedef struct packed {
    logic       external_bus_enable;
    logic [7:0] external_bus_high_byte_enable;
    logic       pin15_audio_clock_select;
    logic       pin7_spi_select_choice;
  } alt_sel_type;

  // function carried by a port A pin
  typedef enum logic [2:0] {
    PF_GPIO    = 3'h0,
    PF_PWM     = 3'h1,
    PF_AUDIO   = 3'h2,
    PF_EXT_BUS = 3'h3,
    PF_I2C     = 3'h4,
    PF_SPI_SEL = 3'h5,
    PF_ADC     = 3'h6
  } pin_func_type;

  // low-voltage reset settle states
  typedef enum logic [2:0] {
    LVR_OFF    = 3'b001,
    LVR_SETTLE = 3'b010,
    LVR_VALID  = 3'b100
  } lvr_state_type;

  // protection unlock sequence states
  typedef enum logic [3:0] {
    UL_IDLE = 4'b0001,
    UL_GOT0 = 4'b0010,
    UL_GOT1 = 4'b0100,
    UL_OPEN = 4'b1000
  } unlock_state_type;

endpackage

// ===== hw/sys_ctrl_bod_por_porta_mux.sv
// Purpose: brownout, low-voltage reset, thermal sensor, power-on-reset code
//          and port A pin function control registers
// Assumes: all inputs but arst_n_i synchronous to core_clk_i at 10 MHz
// Notes:   protected fields are written only after the three-byte unlock sequence
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`include "sys_ctrl_regs.svh"

// Functional notes
// - unlock 59h 16h 88h before protected writes
// - threshold default from config bits 22:21
// - reset select bit20, enable bit23 from config
// - LVR enable default 1, valid after 100us
// - status bit6 below threshold, zero if disabled
// - bit5 low-power mode, default normal
// - bit4 flags crossings, write one clears
// - bit3 picks chip reset or interrupt
// - interrupt held until detector enable cleared
// - thermal sensor enable bit0, default 0
// - code 0x5AA5 disables power-on reset
// - other code or reset re-enables power-on reset
// - bits 31:16 enable port A Schmitt inputs
// - pin15 GPIO, PWM3 or audio clock
// - pins14-12 PWM/bus, pins11-10 I2C1/strobes
// - pins9-8 GPIO or I2C0 SCL/SDA
// - pin7 bus6/SPI select/ADC7, pin6 bus7/ADC6
// - pins5-2 ADC or bus bits 8..11
module sys_ctrl_bod_por_porta_mux #(
  parameter int ADDR_W = 9,                  // byte address width
  parameter int PINS   = 16                  // port A pin count
) (
  // clock, reset, enable
  input  wire logic                          core_clk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          clk_en_i,
  // register port
  input  wire logic [ADDR_W-1:0]             addr_i,
  input  wire logic [31:0]                   wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [31:0]                   rdata_o,
  // configuration and analog status
  input  wire logic [31:0]                   flash_user_config_word_i,
  input  wire logic                          supply_below_i,
  input  wire logic                          other_reset_i,
  input  wire sys_ctrl_pkg::alt_sel_type     alt_sel_i,
  // detector, reset and sensor controls
  output sys_ctrl_pkg::uv_ctrl_type          uv_ctrl_o,
  output logic                               lvr_valid_o,
  output logic                               uv_chip_reset_o,
  output logic                               uv_irq_o,
  output logic                               por_disable_o,
  output logic                               thermal_sensor_enable_o,
  output logic                               unlocked_o,
  // port A pin controls
  output logic      [PINS-1:0]               porta_schmitt_enable_o,
  output sys_ctrl_pkg::pin_func_type         pin_func_o [PINS-1:2],
  // block interrupt
  output logic                               irq_o
);

  localparam logic [10:0] LVR_CYC = 11'(`LVR_SETTLE_CYC);  // 1000 cycles

  // pin function decode for one port A pin
  function automatic sys_ctrl_pkg::pin_func_type pin_decode(
    input int                        idx,
    input logic                      sel,
    input sys_ctrl_pkg::alt_sel_type alt
  );
    logic ebi;
    logic [7:0] hb;
    pin_decode = sys_ctrl_pkg::PF_GPIO;
    ebi = alt.external_bus_enable;
    hb  = alt.external_bus_high_byte_enable;
    if (sel) begin
      case (idx)
        15: pin_decode = alt.pin15_audio_clock_select ? sys_ctrl_pkg::PF_AUDIO
                                                      : sys_ctrl_pkg::PF_PWM;
        14, 13, 12: pin_decode = (ebi && hb[idx-7]) ? sys_ctrl_pkg::PF_EXT_BUS
                                                    : sys_ctrl_pkg::PF_PWM;
        11, 10: pin_decode = ebi ? sys_ctrl_pkg::PF_EXT_BUS
                                 : sys_ctrl_pkg::PF_I2C;
        9, 8: pin_decode = sys_ctrl_pkg::PF_I2C;
        7: begin
          if (ebi) begin
            pin_decode = sys_ctrl_pkg::PF_EXT_BUS;
          end else if (alt.pin7_spi_select_choice) begin
            pin_decode = sys_ctrl_pkg::PF_SPI_SEL;
          end else begin
            pin_decode = sys_ctrl_pkg::PF_ADC;
          end
        end
        6: pin_decode = ebi ? sys_ctrl_pkg::PF_EXT_BUS
                            : sys_ctrl_pkg::PF_ADC;
        5, 4, 3, 2: pin_decode = (ebi && hb[5-idx]) ? sys_ctrl_pkg::PF_EXT_BUS
                                                    : sys_ctrl_pkg::PF_ADC;
        default: pin_decode = sys_ctrl_pkg::PF_GPIO;
      endcase
    end
  endfunction

  // register state
  logic                            cfg_loaded_r;    // config defaults taken
  logic                            cfg_loaded_nxt;
  sys_ctrl_pkg::uv_ctrl_type       uv_ctrl_r;       // protected detector fields
  sys_ctrl_pkg::uv_ctrl_type       uv_ctrl_nxt;
  logic                            uv_flag_r;       // crossing flag
  logic                            uv_flag_nxt;
  logic                            below_prev_r;    // last supply comparison
  logic                            below_prev_nxt;
  logic                            uv_int_r;        // held detector interrupt
  logic                            uv_int_nxt;
  logic                            thermal_r;       // sensor enable
  logic                            thermal_nxt;
  logic [15:0]                     por_code_r;      // power-on reset code
  logic [15:0]                     por_code_nxt;
  logic [31:0]                     porta_r;         // schmitt and function bits
  logic [31:0]                     porta_nxt;
  logic [`IRQ_W-1:0]               irq_stat_r;      // sticky events
  logic [`IRQ_W-1:0]               irq_stat_nxt;
  logic [`IRQ_W-1:0]               irq_mask_r;      // event mask
  logic [`IRQ_W-1:0]               irq_mask_nxt;
  logic [31:0]                     rdata_r;         // read data stage
  logic [31:0]                     rdata_nxt;

  // low-voltage reset settle and unlock state
  sys_ctrl_pkg::lvr_state_type     lvr_st_r;
  sys_ctrl_pkg::lvr_state_type     lvr_st_nxt;
  logic [10:0]                     lvr_cnt_r;
  logic [10:0]                     lvr_cnt_nxt;
  sys_ctrl_pkg::unlock_state_type  ul_st_r;
  sys_ctrl_pkg::unlock_state_type  ul_st_nxt;

  // decoded strobes and derived events
  logic                            wr_uv;           // write brownout_control
  logic                            wr_temp;         // write thermal control
  logic                            wr_por;          // write power-on reset code
  logic                            wr_porta;        // write port A select
  logic                            wr_mask;         // write irq mask
  logic                            wr_unlock;       // write unlock register
  logic                            rd_stat;         // read irq status
  logic                            unlocked;        // protection open
  logic                            uv_status;       // gated detector output
  logic                            uv_cross;        // threshold crossing
  logic                            lvr_ready_ev;    // settle just finished
  logic                            prot_viol;       // locked protected write

  // address decode
  always_comb begin
    wr_uv     = wr_i && (addr_i == `OFS_BROWNOUT_CONTROL);
    wr_temp   = wr_i && (addr_i == `OFS_TEMP_SENSOR_CTRL);
    wr_por    = wr_i && (addr_i == `OFS_POWER_ON_RST_CTRL);
    wr_porta  = wr_i && (addr_i == `OFS_PORTA_FUNC_SELECT);
    wr_mask   = wr_i && (addr_i == `OFS_IRQ_MASK);
    wr_unlock = wr_i && (addr_i == `OFS_PROTECTION_UNLOCK);
    rd_stat   = rd_i && (addr_i == `OFS_IRQ_STATUS);
    unlocked  = (ul_st_r == sys_ctrl_pkg::UL_OPEN);
    uv_status = uv_ctrl_r.enable && supply_below_i;
    uv_cross  = uv_ctrl_r.enable && (supply_below_i != below_prev_r);
    prot_viol = !unlocked && (wr_uv || wr_por);
  end

  // unlock sequence: next state
  always_comb begin
    ul_st_nxt = ul_st_r;
    if (wr_unlock) begin
      case (ul_st_r)
        sys_ctrl_pkg::UL_IDLE: ul_st_nxt = (wdata_i[7:0] == `UNLOCK_BYTE0) ?
                                           sys_ctrl_pkg::UL_GOT0 : sys_ctrl_pkg::UL_IDLE;
        sys_ctrl_pkg::UL_GOT0: ul_st_nxt = (wdata_i[7:0] == `UNLOCK_BYTE1) ?
                                           sys_ctrl_pkg::UL_GOT1 : sys_ctrl_pkg::UL_IDLE;
        sys_ctrl_pkg::UL_GOT1: ul_st_nxt = (wdata_i[7:0] == `UNLOCK_BYTE2) ?
                                           sys_ctrl_pkg::UL_OPEN : sys_ctrl_pkg::UL_IDLE;
        sys_ctrl_pkg::UL_OPEN: ul_st_nxt = sys_ctrl_pkg::UL_IDLE;  // any unlock-register write relocks
        default:               ul_st_nxt = sys_ctrl_pkg::UL_IDLE;
      endcase
    end
  end

  // unlock sequence: registers
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ul_st_r <= sys_ctrl_pkg::UL_IDLE;
    end else if (clk_en_i) begin
      ul_st_r <= ul_st_nxt;
    end
  end

  // low-voltage reset settle: next state
  always_comb begin
    lvr_st_nxt   = lvr_st_r;
    lvr_cnt_nxt  = lvr_cnt_r;
    lvr_ready_ev = 1'b0;
    case (lvr_st_r)
      sys_ctrl_pkg::LVR_OFF: begin
        lvr_cnt_nxt = 11'h000;
        if (uv_ctrl_r.lvr_on && cfg_loaded_r) begin
          lvr_st_nxt = sys_ctrl_pkg::LVR_SETTLE;
        end
      end
      sys_ctrl_pkg::LVR_SETTLE: begin
        if (!uv_ctrl_r.lvr_on) begin
          lvr_st_nxt = sys_ctrl_pkg::LVR_OFF;
        end else if (lvr_cnt_r == LVR_CYC - 11'h001) begin
          lvr_st_nxt   = sys_ctrl_pkg::LVR_VALID;
          lvr_ready_ev = 1'b1;
        end else begin
          lvr_cnt_nxt = lvr_cnt_r + 11'h001;
        end
      end
      sys_ctrl_pkg::LVR_VALID: begin
        if (!uv_ctrl_r.lvr_on) begin
          lvr_st_nxt = sys_ctrl_pkg::LVR_OFF;
        end
      end
      default: lvr_st_nxt = sys_ctrl_pkg::LVR_OFF;
    endcase
  end

  // low-voltage reset settle: registers
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lvr_st_r  <= sys_ctrl_pkg::LVR_OFF;
      lvr_cnt_r <= 11'h000;
    end else if (clk_en_i) begin
      lvr_st_r  <= lvr_st_nxt;
      lvr_cnt_r <= lvr_cnt_nxt;
    end
  end

  // control registers: next values
  always_comb begin
    cfg_loaded_nxt = 1'b1;
    uv_ctrl_nxt    = uv_ctrl_r;
    uv_flag_nxt    = uv_flag_r;
    below_prev_nxt = supply_below_i;
    uv_int_nxt     = uv_int_r;
    thermal_nxt    = thermal_r;
    por_code_nxt   = por_code_r;
    porta_nxt      = porta_r;
    irq_stat_nxt   = irq_stat_r;
    irq_mask_nxt   = irq_mask_r;
    rdata_nxt      = 32'h0000_0000;
    // defaults from the flash user config word, once after reset
    if (!cfg_loaded_r) begin
      uv_ctrl_nxt.threshold = {flash_user_config_word_i[`CFG_BIT_THRESH_HI],
                               flash_user_config_word_i[`CFG_BIT_THRESH_LO]};
      uv_ctrl_nxt.rst_sel   = flash_user_config_word_i[`CFG_BIT_RESET_SELECT];
      uv_ctrl_nxt.enable    = flash_user_config_word_i[`CFG_BIT_UV_ENABLE];
    end
    // protected detector fields, only while unlocked
    if (wr_uv && unlocked) begin
      uv_ctrl_nxt.lvr_on    = wdata_i[`BIT_LVR_ON];
      uv_ctrl_nxt.low_power = wdata_i[`BIT_UV_LOW_POWER];
      uv_ctrl_nxt.rst_sel   = wdata_i[`BIT_UV_RESET_SELECT];
      uv_ctrl_nxt.threshold = wdata_i[`BIT_UV_THRESH_HI:`BIT_UV_THRESH_LO];
      uv_ctrl_nxt.enable    = wdata_i[`BIT_UV_ENABLE];
    end
    // crossing flag: write one clears, a new crossing wins
    if (wr_uv && wdata_i[`BIT_UV_EVENT_FLAG]) begin
      uv_flag_nxt = 1'b0;
    end
    if (uv_cross) begin
      uv_flag_nxt = 1'b1;
    end
    // detector interrupt held until the detector is disabled
    if (!uv_ctrl_r.enable) begin
      uv_int_nxt = 1'b0;
    end else if (uv_status && !uv_ctrl_r.rst_sel) begin
      uv_int_nxt = 1'b1;
    end
    // thermal sensor enable, unprotected
    if (wr_temp) begin
      thermal_nxt = wdata_i[`BIT_THERMAL_EN];
    end
    // power-on reset code: protected write, cleared by other resets
    if (wr_por && unlocked) begin
      por_code_nxt = wdata_i[`POS_POR_CODE_HI:0];
    end
    if (other_reset_i) begin
      por_code_nxt = `RST_POR_CODE;
    end
    // port A schmitt and function bits, unprotected
    if (wr_porta) begin
      porta_nxt = wdata_i;
    end
    if (wr_mask) begin
      irq_mask_nxt = wdata_i[`IRQ_W-1:0];
    end
    // sticky status: a read clears, an event in the same cycle wins
    if (rd_stat) begin
      irq_stat_nxt = '0;
    end
    irq_stat_nxt[`IRQ_BIT_UV_CROSS]       = irq_stat_nxt[`IRQ_BIT_UV_CROSS] | uv_cross;
    irq_stat_nxt[`IRQ_BIT_LVR_READY]      = irq_stat_nxt[`IRQ_BIT_LVR_READY] | lvr_ready_ev;
    irq_stat_nxt[`IRQ_BIT_PROT_VIOLATION] = irq_stat_nxt[`IRQ_BIT_PROT_VIOLATION] | prot_viol;
    // read data mux, unmapped reads return zero
    if (rd_i) begin
      case (addr_i)
        `OFS_BROWNOUT_CONTROL:  rdata_nxt = {24'h00_0000, uv_ctrl_r.lvr_on, uv_status,
                                             uv_ctrl_r.low_power, uv_flag_r,
                                             uv_ctrl_r.rst_sel, uv_ctrl_r.threshold,
                                             uv_ctrl_r.enable};
        `OFS_TEMP_SENSOR_CTRL:  rdata_nxt = {31'h0000_0000, thermal_r};
        `OFS_POWER_ON_RST_CTRL: rdata_nxt = {16'h0000, por_code_r};
        `OFS_PORTA_FUNC_SELECT: rdata_nxt = porta_r;
        `OFS_IRQ_STATUS:        rdata_nxt = {29'h0000_0000, irq_stat_r};
        `OFS_IRQ_MASK:          rdata_nxt = {29'h0000_0000, irq_mask_r};
        `OFS_PROTECTION_UNLOCK: rdata_nxt = {31'h0000_0000, unlocked};
        default:                rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // control registers: state
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_loaded_r <= 1'b0;
      uv_ctrl_r    <= '{lvr_on: `RST_LVR_ON, low_power: `RST_UV_LOW_POWER,
                        rst_sel: 1'b0, threshold: 2'h0, enable: 1'b0};
      uv_flag_r    <= 1'b0;
      below_prev_r <= 1'b0;
      uv_int_r     <= 1'b0;
      thermal_r    <= `RST_THERMAL_EN;
      por_code_r   <= `RST_POR_CODE;
      porta_r      <= `RST_PORTA_FUNC;
      irq_stat_r   <= '0;
      irq_mask_r   <= `RST_IRQ_MASK;
      rdata_r      <= 32'h0000_0000;
    end else if (clk_en_i) begin
      cfg_loaded_r <= cfg_loaded_nxt;
      uv_ctrl_r    <= uv_ctrl_nxt;
      uv_flag_r    <= uv_flag_nxt;
      below_prev_r <= below_prev_nxt;
      uv_int_r     <= uv_int_nxt;
      thermal_r    <= thermal_nxt;
      por_code_r   <= por_code_nxt;
      porta_r      <= porta_nxt;
      irq_stat_r   <= irq_stat_nxt;
      irq_mask_r   <= irq_mask_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  // pin function outputs, one decoder per pin from pin 2 up
  genvar gp;
  generate
    for (gp = 2; gp < PINS; gp++) begin : g_pin
      assign pin_func_o[gp] = pin_decode(gp, porta_r[gp], alt_sel_i);
    end
  endgenerate

  // output drive
  assign rdata_o                 = rdata_r;
  assign uv_ctrl_o               = uv_ctrl_r;
  assign lvr_valid_o             = (lvr_st_r == sys_ctrl_pkg::LVR_VALID);
  assign uv_chip_reset_o         = uv_status && uv_ctrl_r.rst_sel;
  assign uv_irq_o                = uv_int_r;
  assign por_disable_o           = (por_code_r == `POR_DISABLE_CODE);
  assign thermal_sensor_enable_o = thermal_r;
  assign unlocked_o              = unlocked;
  assign porta_schmitt_enable_o  = porta_r[`POS_SCHMITT_LO +: PINS];
  assign irq_o                   = |(irq_stat_r & irq_mask_r);

endmodule

// ===== tb/sys_ctrl_chk_assertions.sv
// Purpose: port-level checks of the brownout, reset code and port A block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to the block below the module
`timescale 1ns/100ps
module sys_ctrl_chk #(
  parameter int ADDR_W = 9,
  parameter int PINS   = 16
) (
  // clock and reset
  input wire logic                      core_clk_i,
  input wire logic                      arst_n_i,
  input wire logic                      clk_en_i,
  // register port
  input wire logic [ADDR_W-1:0]         addr_i,
  input wire logic [31:0]               wdata_i,
  input wire logic                      wr_i,
  input wire logic                      rd_i,
  input wire logic [31:0]               rdata_o,
  // analog side
  input wire logic                      supply_below_i,
  input wire logic                      other_reset_i,
  input wire sys_ctrl_pkg::uv_ctrl_type uv_ctrl_o,
  input wire logic                      lvr_valid_o,
  input wire logic                      uv_chip_reset_o,
  input wire logic                      uv_irq_o,
  input wire logic                      por_disable_o,
  input wire logic                      unlocked_o,
  input wire logic [PINS-1:0]           porta_schmitt_enable_o
);
  logic [1:0] age_r;    // enabled edges since reset, saturates at three
  logic [1:0] age_nxt;  // next edge count
  // count past the config load edge
  always_comb begin
    age_nxt = age_r;
    if (clk_en_i && age_r != 2'h3) begin
      age_nxt = age_r + 2'h1;
    end
  end
  // register the count
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      age_r <= 2'h0;
    end else begin
      age_r <= age_nxt;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_read_data_idle: assert property ((clk_en_i && !rd_i) |=> rdata_o == 32'h0) else $error("read data not idle");
  a_chip_reset_cause: assert property (uv_chip_reset_o == (uv_ctrl_o.enable && supply_below_i && uv_ctrl_o.rst_sel)) else $error("chip reset wrong");
  a_uv_irq_set: assert property ((clk_en_i && uv_ctrl_o.enable && supply_below_i && !uv_ctrl_o.rst_sel) |=> uv_irq_o) else $error("detector irq missing");
  a_uv_irq_hold: assert property ((uv_irq_o && uv_ctrl_o.enable) |=> uv_irq_o) else $error("detector irq dropped");
  a_uv_irq_drop: assert property ((clk_en_i && !uv_ctrl_o.enable) |=> !uv_irq_o) else $error("detector irq not cleared");
  a_por_code_clear: assert property ((clk_en_i && other_reset_i) |=> !por_disable_o) else $error("power-on reset still off");
  a_locked_no_change: assert property ((age_r == 2'h3 && !unlocked_o) |=> $stable(uv_ctrl_o)) else $error("locked field changed");
  a_schmitt_follows: assert property ((clk_en_i && wr_i && addr_i == 9'h030) |=> porta_schmitt_enable_o == $past(wdata_i[31:16])) else $error("schmitt bits wrong");
  a_lvr_settle_wait: assert property ($rose(uv_ctrl_o.lvr_on) |=> !lvr_valid_o [*8]) else $error("reset output valid too soon");
  a_lvr_off_invalid: assert property ((clk_en_i && !uv_ctrl_o.lvr_on) |=> !lvr_valid_o) else $error("reset output valid while off");
  c_uv_irq: cover property ($rose(uv_irq_o));
  c_por_off: cover property ($rose(por_disable_o));
  c_lvr_ready: cover property ($rose(lvr_valid_o));
endmodule
bind sys_ctrl_bod_por_porta_mux sys_ctrl_chk #(.ADDR_W(ADDR_W), .PINS(PINS)) chk_i (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .supply_below_i(supply_below_i),
  .other_reset_i(other_reset_i), .uv_ctrl_o(uv_ctrl_o), .lvr_valid_o(lvr_valid_o),
  .uv_chip_reset_o(uv_chip_reset_o), .uv_irq_o(uv_irq_o), .por_disable_o(por_disable_o),
  .unlocked_o(unlocked_o), .porta_schmitt_enable_o(porta_schmitt_enable_o));

// ===== tb/sys_ctrl_bod_por_porta_mux_tb.sv
// Purpose: self-checking bench of the brownout and port A control block
// Assumes: config word enables the detector at 3.8V in interrupt mode
// Notes:   one strobe per bus task, a cycle apart
`timescale 1ns/100ps
module sys_ctrl_bod_por_porta_mux_tb;
  logic                       core_clk_i = 1'b0;
  logic                       arst_n_i = 1'b0;
  logic [8:0]                 addr_i = 9'h000;
  logic [31:0]                wdata_i = 32'h0;
  logic                       wr_i = 1'b0;
  logic                       rd_i = 1'b0;
  logic                       supply_below_i = 1'b0;
  logic                       other_reset_i = 1'b0;
  sys_ctrl_pkg::alt_sel_type  alt_sel_i = '0;
  sys_ctrl_pkg::uv_ctrl_type  uv_ctrl_o;
  sys_ctrl_pkg::pin_func_type pin_func_o [15:2];
  logic [31:0]                rdata_o;
  logic [15:0]                porta_schmitt_enable_o;
  logic lvr_valid_o, uv_chip_reset_o, uv_irq_o, por_disable_o, thermal_sensor_enable_o;
  logic unlocked_o, irq_o;
  int miscompares = 0;
  int tests_run = 0;
  sys_ctrl_bod_por_porta_mux dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .flash_user_config_word_i(32'h00c0_0000), .supply_below_i(supply_below_i),
    .other_reset_i(other_reset_i), .alt_sel_i(alt_sel_i), .uv_ctrl_o(uv_ctrl_o),
    .lvr_valid_o(lvr_valid_o), .uv_chip_reset_o(uv_chip_reset_o), .uv_irq_o(uv_irq_o),
    .por_disable_o(por_disable_o), .thermal_sensor_enable_o(thermal_sensor_enable_o),
    .unlocked_o(unlocked_o), .porta_schmitt_enable_o(porta_schmitt_enable_o),
    .pin_func_o(pin_func_o), .irq_o(irq_o));
  always #50 core_clk_i = ~core_clk_i;  // 10 MHz
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  task automatic t_defaults;
    rd(9'h018, 32'h85);
    rd(9'h024, 32'h0);
    rd(9'h008, 32'h0);
    rd(9'h1c, 32'h0);
    wr(9'h01c, 32'h1);
    chk(thermal_sensor_enable_o, 1);
  endtask
  task automatic t_protect;
    wr(9'h018, 32'h0);
    wr(9'h024, 32'h5aa5);
    rd(9'h018, 32'h85);
    rd(9'h024, 32'h0);
    rd(9'h040, 32'h4);
    wr(9'h100, 32'h59);
    wr(9'h100, 32'h16);
    wr(9'h100, 32'h88);
    chk(unlocked_o, 1);
  endtask
  task automatic t_por;
    wr(9'h024, 32'h5aa5);
    chk(por_disable_o, 1);
    @(posedge core_clk_i) other_reset_i <= 1'b1;
    @(posedge core_clk_i) other_reset_i <= 1'b0;
    rd(9'h024, 32'h0);
    wr(9'h024, 32'h5aa5);
    wr(9'h024, 32'h5aa4);
    chk(por_disable_o, 0);
  endtask
  task automatic t_brownout;
    wr(9'h044, 32'h1);
    @(posedge core_clk_i) supply_below_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1 chk(uv_irq_o, 1);
    chk(irq_o, 1);
    rd(9'h018, 32'hd5);
    @(posedge core_clk_i) supply_below_i <= 1'b0;
    rd(9'h040, 32'h1);
    chk(irq_o, 0);
    chk(uv_irq_o, 1);
    wr(9'h018, 32'h95);
    rd(9'h018, 32'h85);
    wr(9'h018, 32'h84);
    @(posedge core_clk_i) supply_below_i <= 1'b1;
    #1 chk(uv_irq_o, 0);
    rd(9'h018, 32'h84);
    wr(9'h018, 32'h8d);
    chk(uv_chip_reset_o, 1);
    rd(9'h018, 32'hcd);
    @(posedge core_clk_i) supply_below_i <= 1'b0;
    wr(9'h018, 32'hb4);
    chk(uv_ctrl_o, 6'h34);
    rd(9'h018, 32'ha4);
  endtask
  task automatic t_porta;
    wr(9'h030, 32'ha5a5_ffff);
    chk(porta_schmitt_enable_o, 16'ha5a5);
    chk(pin_func_o[15], sys_ctrl_pkg::PF_PWM);
    chk(pin_func_o[14], sys_ctrl_pkg::PF_PWM);
    chk(pin_func_o[11], sys_ctrl_pkg::PF_I2C);
    chk(pin_func_o[8], sys_ctrl_pkg::PF_I2C);
    chk(pin_func_o[7], sys_ctrl_pkg::PF_ADC);
    chk(pin_func_o[2], sys_ctrl_pkg::PF_ADC);
    @(posedge core_clk_i) alt_sel_i <= 11'h7fe;
    #1 chk(pin_func_o[15], sys_ctrl_pkg::PF_AUDIO);
    chk(pin_func_o[12], sys_ctrl_pkg::PF_EXT_BUS);
    chk(pin_func_o[10], sys_ctrl_pkg::PF_EXT_BUS);
    chk(pin_func_o[9], sys_ctrl_pkg::PF_I2C);
    chk(pin_func_o[6], sys_ctrl_pkg::PF_EXT_BUS);
    chk(pin_func_o[5], sys_ctrl_pkg::PF_EXT_BUS);
    @(posedge core_clk_i) alt_sel_i <= 11'h401;
    #1 chk(pin_func_o[7], sys_ctrl_pkg::PF_EXT_BUS);
    chk(pin_func_o[3], sys_ctrl_pkg::PF_ADC);
    @(posedge core_clk_i) alt_sel_i <= 11'h001;
    #1 chk(pin_func_o[7], sys_ctrl_pkg::PF_SPI_SEL);
    wr(9'h030, 32'h0);
    chk(pin_func_o[15], sys_ctrl_pkg::PF_GPIO);
  endtask
  task automatic t_lvr;
    for (int i = 0; i < 1200 && lvr_valid_o !== 1'b1; i++) @(posedge core_clk_i);
    #1 chk(lvr_valid_o, 1);
    wr(9'h018, 32'h04);
    wr(9'h018, 32'h84);
    repeat (900) @(posedge core_clk_i);
    #1 chk(lvr_valid_o, 0);
    repeat (150) @(posedge core_clk_i);
    #1 chk(lvr_valid_o, 1);
    wr(9'h100, 32'h0);
    chk(unlocked_o, 0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    t_defaults();
    t_protect();
    t_por();
    t_brownout();
    t_porta();
    t_lvr();
    complete_run();
  end
endmodule
